//--- clock_select_defines.svh
// What this block does
// - Bus clock is primary input, halved by strap
// - Strap level is captured at reset only
// - Memory clock divides bus clock by 1..4
// - Pixel clock source and divisor from register
// - PWM clock source from register bits 2-1
// - Each function runs only its needed clocks
// - Nothing but PWM depends on PWM clock
// - Unneeded clocks are gated off
// - EOP rejected under 40 ns, accepted 80 ns
`ifndef CLOCK_SELECT_DEFINES_SVH
`define CLOCK_SELECT_DEFINES_SVH

`define REG_ADDR_W 8
`define REG_MEM_CLOCK 8'h04
`define REG_PIXEL_CLOCK 8'h08
`define REG_PWM_CLOCK 8'h70

`define MEM_DIV_HI 5
`define MEM_DIV_LO 4
`define STRAP_VIEW_BIT 7
`define PIX_SRC_HI 1
`define PIX_SRC_LO 0
`define PIX_DIV_HI 6
`define PIX_DIV_LO 4
`define PWM_SRC_HI 2
`define PWM_SRC_LO 1

`define PIX_DIV_CODE_MAX 3'h3
`define PIX_LIM_EIGHT 3'h7

`define PIN_PRI 0
`define PIN_SEC 1
`define PIN_DP 2
`define PIN_DM 3
`define PIN_STRAP 4
`define PIN_COUNT 5

`define CLK_PERIOD_NS 40
`define EOP_REJECT_NS 40
`define EOP_ACCEPT_NS 80
`define EOP_ACCEPT_CYC (`EOP_ACCEPT_NS / `CLK_PERIOD_NS)
`define EOP_CNT_W 2

`endif

//--- clock_select_pkg.sv
package clock_select_pkg;

  typedef enum logic [1:0] {
    PIX_FROM_MEM = 2'h0,
    PIX_FROM_BUS = 2'h1,
    PIX_FROM_PRI = 2'h2,
    PIX_FROM_SEC = 2'h3
  } pix_src_t;

  typedef enum logic [1:0] {
    PWM_FROM_PRI = 2'h0,
    PWM_FROM_SEC = 2'h1,
    PWM_FROM_MEM = 2'h2,
    PWM_FROM_PIX = 2'h3
  } pwm_src_t;

endpackage

//--- clock_select.sv
`timescale 1ns/1ps
`include "clock_select_defines.svh"

module clock_select
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins from outside the clock domain
  input wire logic primary_clock_input,
  input wire logic secondary_clock_input,
  input wire logic bus_clock_divide_strap,
  input wire logic usb_dp,
  input wire logic usb_dm,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Function activity
  input wire logic reg_access,
  input wire logic mem_access,
  input wire logic lut_access,
  input wire logic sw_power_save,
  input wire logic panel_on,
  input wire logic usb_access,
  input wire logic pwm_enable,
  // Clock enables and status
  output logic bus_clk_en,
  output logic mem_clk_en,
  output logic pix_clk_en,
  output logic pwm_clk_en,
  output logic usb_clock_run,
  output logic usb_eop
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [`PIN_COUNT-1:0] sync1_q;
  logic [`PIN_COUNT-1:0] sync2_q;
  logic [`PIN_COUNT-1:0] sync3_q;
  logic [`PIN_COUNT-1:0] pin_q;
  logic [`PIN_COUNT-1:0] pin_d;

  // A level is taken only once the second and third stages agree.
  always_comb
  begin
    pin_d = (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
  end

  // The chain is not reset. The strap must reach the capture stage while reset
  // is held, and a cleared stage would fake a pin edge or a bus zero after release.
  always_ff @(posedge clk)
  begin
    sync1_q <= {bus_clock_divide_strap, usb_dm, usb_dp, secondary_clock_input,
                primary_clock_input};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    pin_q <= pin_d;
  end

  logic pri_tick;
  logic sec_tick;
  assign pri_tick = pin_d[`PIN_PRI] & ~pin_q[`PIN_PRI];
  assign sec_tick = pin_d[`PIN_SEC] & ~pin_q[`PIN_SEC];

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [1:0] mem_div_q;
  logic [1:0] mem_div_d;
  clock_select_pkg::pix_src_t pix_src_cfg_q;
  clock_select_pkg::pix_src_t pix_src_cfg_d;
  logic [2:0] pix_div_cfg_q;
  logic [2:0] pix_div_cfg_d;
  clock_select_pkg::pwm_src_t pwm_src_q;
  clock_select_pkg::pwm_src_t pwm_src_d;
  logic strap_q;
  logic strap_d;
  logic [31:0] rdata_d;

  always_comb
  begin
    mem_div_d = mem_div_q;
    pix_src_cfg_d = pix_src_cfg_q;
    pix_div_cfg_d = pix_div_cfg_q;
    pwm_src_d = pwm_src_q;
    rdata_d = reg_rdata;
    strap_d = strap_q;
    // The strap is only looked at while reset is held.
    if (srst)
    begin
      strap_d = pin_q[`PIN_STRAP];
    end
    if (reg_sel && reg_wr)
    begin
      unique case (reg_addr)
        `REG_MEM_CLOCK:
        begin
          mem_div_d = reg_wdata[`MEM_DIV_HI:`MEM_DIV_LO];
        end
        `REG_PIXEL_CLOCK:
        begin
          pix_src_cfg_d = clock_select_pkg::pix_src_t'(reg_wdata[`PIX_SRC_HI:`PIX_SRC_LO]);
          pix_div_cfg_d = reg_wdata[`PIX_DIV_HI:`PIX_DIV_LO];
        end
        `REG_PWM_CLOCK:
        begin
          pwm_src_d = clock_select_pkg::pwm_src_t'(reg_wdata[`PWM_SRC_HI:`PWM_SRC_LO]);
        end
        default:
        begin
        end
      endcase
    end
    if (reg_sel && reg_rd)
    begin
      rdata_d = '0;
      unique case (reg_addr)
        `REG_MEM_CLOCK:
        begin
          rdata_d[`MEM_DIV_HI:`MEM_DIV_LO] = mem_div_q;
          rdata_d[`STRAP_VIEW_BIT] = strap_q;
        end
        `REG_PIXEL_CLOCK:
        begin
          rdata_d[`PIX_SRC_HI:`PIX_SRC_LO] = pix_src_cfg_q;
          rdata_d[`PIX_DIV_HI:`PIX_DIV_LO] = pix_div_cfg_q;
        end
        `REG_PWM_CLOCK:
        begin
          rdata_d[`PWM_SRC_HI:`PWM_SRC_LO] = pwm_src_q;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mem_div_q <= '0;
      pix_src_cfg_q <= clock_select_pkg::PIX_FROM_MEM;
      pix_div_cfg_q <= '0;
      pwm_src_q <= clock_select_pkg::PWM_FROM_PRI;
      reg_rdata <= '0;
    end
    else
    begin
      mem_div_q <= mem_div_d;
      pix_src_cfg_q <= pix_src_cfg_d;
      pix_div_cfg_q <= pix_div_cfg_d;
      pwm_src_q <= pwm_src_d;
      reg_rdata <= rdata_d;
    end
    strap_q <= strap_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers. Derived clocks are one-cycle enables on clk.

  // Next count of a divider that wraps at lim on each source tick.
  function automatic logic [2:0] div_next(logic [2:0] cnt, logic [2:0] lim, logic tick);
    logic [2:0] nxt;
    nxt = cnt;
    if (tick)
    begin
      nxt = (cnt >= lim) ? 3'h0 : 3'(cnt + 3'h1);
    end
    return nxt;
  endfunction

  // Codes above the documented range fall back to divide by eight.
  function automatic logic [2:0] pix_limit(logic [2:0] code);
    return (code > `PIX_DIV_CODE_MAX) ? `PIX_LIM_EIGHT : code;
  endfunction

  logic bus_half_q;
  logic bus_half_d;
  logic [2:0] mem_cnt_q;
  logic [2:0] mem_cnt_d;
  logic [1:0] mem_lim_q;
  logic [1:0] mem_lim_d;
  logic [2:0] pix_cnt_q;
  logic [2:0] pix_cnt_d;
  logic [2:0] pix_lim_q;
  logic [2:0] pix_lim_d;
  clock_select_pkg::pix_src_t pix_src_q;
  clock_select_pkg::pix_src_t pix_src_d;
  clock_select_pkg::pwm_src_t pwm_src_act_q;
  clock_select_pkg::pwm_src_t pwm_src_act_d;
  logic bus_tick;
  logic mem_tick;
  logic pix_in_tick;
  logic pix_tick;
  logic pwm_tick;
  logic bus_need;
  logic mem_need;
  logic pix_need;

  assign bus_tick = pri_tick & (~strap_q | bus_half_q);
  assign mem_tick = bus_tick & (mem_cnt_q >= {1'b0, mem_lim_q});
  assign pix_tick = pix_in_tick & (pix_cnt_q >= pix_lim_q);

  always_comb
  begin
    unique case (pix_src_q)
      clock_select_pkg::PIX_FROM_MEM: pix_in_tick = mem_tick;
      clock_select_pkg::PIX_FROM_BUS: pix_in_tick = bus_tick;
      clock_select_pkg::PIX_FROM_PRI: pix_in_tick = pri_tick;
      clock_select_pkg::PIX_FROM_SEC: pix_in_tick = sec_tick;
    endcase
    unique case (pwm_src_act_q)
      clock_select_pkg::PWM_FROM_PRI: pwm_tick = pri_tick;
      clock_select_pkg::PWM_FROM_SEC: pwm_tick = sec_tick;
      clock_select_pkg::PWM_FROM_MEM: pwm_tick = mem_tick;
      clock_select_pkg::PWM_FROM_PIX: pwm_tick = pix_tick;
    endcase
  end

  always_comb
  begin
    bus_half_d = pri_tick ? ~bus_half_q : bus_half_q;
    mem_cnt_d = div_next(mem_cnt_q, {1'b0, mem_lim_q}, bus_tick);
    pix_cnt_d = div_next(pix_cnt_q, pix_lim_q, pix_in_tick);
    mem_lim_d = mem_lim_q;
    pix_lim_d = pix_lim_q;
    pix_src_d = pix_src_q;
    pwm_src_act_d = pwm_src_act_q;
    // New settings load only at a period boundary, so a divisor change never emits a shortened
    // period. A stopped old source delays the change until it runs.
    if (mem_tick)
    begin
      mem_lim_d = mem_div_q;
    end
    if (pix_tick)
    begin
      pix_lim_d = pix_limit(pix_div_cfg_q);
      pix_src_d = pix_src_cfg_q;
    end
    if (pwm_tick)
    begin
      pwm_src_act_d = pwm_src_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_half_q <= 1'b0;
      mem_cnt_q <= '0;
      mem_lim_q <= '0;
      pix_cnt_q <= '0;
      pix_lim_q <= '0;
      pix_src_q <= clock_select_pkg::PIX_FROM_MEM;
      pwm_src_act_q <= clock_select_pkg::PWM_FROM_PRI;
    end
    else
    begin
      bus_half_q <= bus_half_d;
      mem_cnt_q <= mem_cnt_d;
      mem_lim_q <= mem_lim_d;
      pix_cnt_q <= pix_cnt_d;
      pix_lim_q <= pix_lim_d;
      pix_src_q <= pix_src_d;
      pwm_src_act_q <= pwm_src_act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating. Dividers keep running; only the delivered enables stop, which
  // keeps restart phase clean at the cost of a little counter power.

  assign bus_need = reg_access | mem_access | lut_access | sw_power_save | panel_on
                    | usb_access;
  assign mem_need = mem_access | lut_access | panel_on;
  assign pix_need = panel_on;

  logic bus_en_d;
  logic mem_en_d;
  logic pix_en_d;
  logic pwm_en_d;
  logic usb_run_d;

  always_comb
  begin
    bus_en_d = bus_tick & bus_need;
    mem_en_d = mem_tick & mem_need;
    pix_en_d = pix_tick & pix_need;
    pwm_en_d = pwm_tick & pwm_enable;
    usb_run_d = usb_access;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_clk_en <= 1'b0;
      mem_clk_en <= 1'b0;
      pix_clk_en <= 1'b0;
      pwm_clk_en <= 1'b0;
      usb_clock_run <= 1'b0;
    end
    else
    begin
      bus_clk_en <= bus_en_d;
      mem_clk_en <= mem_en_d;
      pix_clk_en <= pix_en_d;
      pwm_clk_en <= pwm_en_d;
      usb_clock_run <= usb_run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // End-of-packet filter. A zero shorter than two samples never reaches here.

  logic se0;
  logic [`EOP_CNT_W-1:0] se0_cnt_q;
  logic [`EOP_CNT_W-1:0] se0_cnt_d;
  logic eop_d;

  assign se0 = ~pin_q[`PIN_DP] & ~pin_q[`PIN_DM];

  always_comb
  begin
    se0_cnt_d = '0;
    eop_d = 1'b0;
    if (se0)
    begin
      se0_cnt_d = (se0_cnt_q == `EOP_CNT_W'(`EOP_ACCEPT_CYC)) ? se0_cnt_q
                  : `EOP_CNT_W'(se0_cnt_q + 1'b1);
      eop_d = (se0_cnt_q == `EOP_CNT_W'(`EOP_ACCEPT_CYC - 1));
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      se0_cnt_q <= '0;
      usb_eop <= 1'b0;
    end
    else
    begin
      se0_cnt_q <= se0_cnt_d;
      usb_eop <= eop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_bus_direct: assert property ((!strap_q && pri_tick && bus_need) |=> bus_clk_en)
    else $error("bus enable missed an undivided primary edge");
  chk_bus_halved: assert property ((strap_q && pri_tick && !bus_half_q) |-> !bus_tick)
    else $error("bus enable fired on a skipped half edge");
  chk_strap_fixed: assert property ($past(!srst) |-> $stable(strap_q))
    else $error("strap changed outside reset");
  chk_mem_undiv: assert property ((mem_lim_q == 2'h0 && bus_tick) |-> mem_tick)
    else $error("memory enable missed an undivided bus tick");
  chk_pix_source: assert property ((pix_src_q == clock_select_pkg::PIX_FROM_SEC && pix_tick)
                                   |-> sec_tick)
    else $error("pixel tick without a secondary edge");
  chk_pwm_source: assert property (pwm_clk_en |-> $past(pwm_tick))
    else $error("pwm enable without a selected source tick");
  chk_mem_gate: assert property (mem_clk_en |-> $past(mem_need))
    else $error("memory enable while no function needs it");
  chk_pwm_gate: assert property (pwm_clk_en |-> $past(pwm_enable))
    else $error("pwm enable while pwm is off");
  chk_eop_width: assert property (usb_eop |-> $past(se0) && $past(se0, 2))
    else $error("end of packet taken from a short zero");
  chk_div_hold: assert property (!mem_tick |=> $stable(mem_lim_q))
    else $error("memory divisor changed mid period");

  cov_halved_bus: cover property (strap_q && bus_clk_en);
  cov_pixel_by_eight: cover property (pix_lim_q == `PIX_LIM_EIGHT && pix_clk_en);
  cov_eop_seen: cover property (usb_eop);
  cov_pwm_from_pixel: cover property (pwm_src_q == clock_select_pkg::PWM_FROM_PIX
                                      && pwm_clk_en);

endmodule

//--- pin_clock_host.sv
`timescale 1ns/1ps
module pin_clock_host
#(
  parameter int HALF_PRI = 4,
  parameter int HALF_SEC = 6
)
(
  // Clock
  input wire logic clk,
  // Pin clocks
  output logic pri_pin,
  output logic sec_pin
);
  int cnt_p = 0;
  int cnt_s = 0;
  logic pri_q = 1'b0;
  logic sec_q = 1'b0;
  assign pri_pin = pri_q;
  assign sec_pin = sec_q;
  ////////////////////////////////////////////////////////////////
  // The host bus clock runs free, so both pins keep toggling through reset.
  always @(posedge clk)
  begin
    cnt_p <= (cnt_p == HALF_PRI - 1) ? 0 : cnt_p + 1;
    cnt_s <= (cnt_s == HALF_SEC - 1) ? 0 : cnt_s + 1;
    if (cnt_p == HALF_PRI - 1)
      pri_q <= #1 ~pri_q;
    if (cnt_s == HALF_SEC - 1)
      sec_q <= #1 ~sec_q;
  end
endmodule

//--- internal_clock_selection_tb_top.sv
`timescale 1ns/1ps
module internal_clock_selection_tb_top;
  logic clk, srst, strap, dp, dm, sel, wr, rd, rd_pend;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [6:0] act;
  wire [3:0] en;
  wire run, eop, pri, sec;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 84;
  int eops = 0;
  logic [31:0] exp_q[$];
  int divs[5] = '{1, 2, 3, 4, 8};
  int base[4] = '{8, 8, 8, 12};
  int pwm_exp[4] = '{8, 12, 16, 16};
  logic [7:0] addrs[3] = '{8'h04, 8'h08, 8'h70};
  logic [31:0] masks[3] = '{32'h00000030, 32'h00000073, 32'h00000006};
  logic [6:0] acts[6] = '{7'h00, 7'h01, 7'h08, 7'h04, 7'h10, 7'h20};
  logic [3:0] runs[6] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h7, 4'h1};

  pin_clock_host pin_clock_host_inst (.clk(clk), .pri_pin(pri), .sec_pin(sec));
  clock_select clock_select_inst (.clk(clk), .srst(srst), .primary_clock_input(pri),
    .secondary_clock_input(sec), .bus_clock_divide_strap(strap), .usb_dp(dp),
    .usb_dm(dm), .reg_sel(sel), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_access(act[0]), .mem_access(act[1]),
    .lut_access(act[2]), .sw_power_save(act[3]), .panel_on(act[4]),
    .usb_access(act[5]), .pwm_enable(act[6]), .bus_clk_en(en[0]), .mem_clk_en(en[1]),
    .pix_clk_en(en[2]), .pwm_clk_en(en[3]), .usb_clock_run(run), .usb_eop(eop));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    sel = 1'b1;
    wr = 1'b1;
    addr = a;
    wdata = v;
    tick(1);
    sel = 1'b0;
    wr = 1'b0;
    tick(1);
  endtask
  // Reads are noted here and judged by the monitor one edge later.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] v);
    exp_q.push_back(v);
    sel = 1'b1;
    rd = 1'b1;
    addr = a;
    tick(1);
    sel = 1'b0;
    rd = 1'b0;
    tick(1);
  endtask
  task automatic period(input int k, input int exp);
    int n;
    n = 0;
    while (en[k] !== 1'b1 && n < 600)
    begin
      tick(1);
      n++;
    end
    tick(1);
    n = 1;
    while (en[k] !== 1'b1 && n < 600)
    begin
      tick(1);
      n++;
    end
    check("enable period", n, exp);
  endtask
  task automatic pulses(input int k, output logic seen);
    seen = 1'b0;
    repeat (64)
    begin
      tick(1);
      if (en[k] === 1'b1)
        seen = 1'b1;
    end
  endtask
  task automatic se0(input int n);
    dp = 1'b0;
    tick(n);
    dp = 1'b1;
    tick(10);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rd_pend === 1'b1)
      check("reg_rdata", rdata, exp_q.pop_front());
    rd_pend <= sel & rd;
    if (eop === 1'b1)
      eops++;
  end
  initial
  begin
    #(40 * 40000);
    num_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic s;
    {srst, strap, sel, wr, rd, dm} = 6'h20;
    dp = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    act = 7'h00;
    // The strap is valid all through reset.
    tick(5);
    srst = 1'b0;
    for (int i = 0; i < 3; i++)
      rd_reg(addrs[i], 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      d = $random(seed);
      wr_reg(addrs[i], d);
      rd_reg(addrs[i], d & masks[i]);
    end
    wr_reg(8'h0c, $random(seed));
    rd_reg(8'h0c, 32'h0);
    act = 7'h52;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h04, i << 4);
      tick(100);
      period(0, 8);
      period(1, 8 * (i + 1));
    end
    wr_reg(8'h04, 32'h0);
    for (int c = 0; c < 5; c++)
    begin
      wr_reg(8'h08, (c << 4) | (c % 4));
      tick(150);
      period(2, base[c % 4] * divs[c]);
    end
    // Divisor codes above the table run at divide by eight.
    wr_reg(8'h08, 32'h71);
    tick(150);
    period(2, base[1] * divs[4]);
    wr_reg(8'h04, 32'h10);
    wr_reg(8'h08, 32'h11);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h70, i << 1);
      tick(150);
      period(3, pwm_exp[i]);
    end
    for (int i = 0; i < 6; i++)
    begin
      act = acts[i];
      tick(60);
      for (int k = 0; k < 3; k++)
      begin
        pulses(k, s);
        check("enable running", s, runs[i][k]);
      end
      pulses(3, s);
      check("pwm running", s, 1'b0);
    end
    check("usb clock run", run, 1'b1);
    act = 7'h00;
    tick(2);
    check("usb clock run", run, 1'b0);
    se0(1);
    se0(4);
    // A low plus line while the minus line is high is no bus zero.
    dm = 1'b1;
    se0(4);
    dm = 1'b0;
    check("eop count", eops, 1);
    srst = 1'b1;
    strap = 1'b1;
    tick(5);
    srst = 1'b0;
    strap = 1'b0;
    act = 7'h01;
    rd_reg(8'h04, 32'h80);
    tick(20);
    period(0, 16);
    stop_test();
  end
endmodule
